// *** hdl/aeb_core.v ***
// Execute stage: byte and word arithmetic, logic, jumps, calls, skips, branches.
// Assumes a decoder on core_clk presents operands with a start pulse while ready.
// Stack storage lives outside; this block only raises push and pop requests.
`timescale 1ns/1ps
`include "aeb_consts.vh"

module aeb_core (
  input wire core_clk,
  input wire reset,
  input wire start,
  input wire [5:0] op,
  input wire [7:0] rd_val,
  input wire [7:0] source_register,
  input wire [7:0] imm_k,
  input wire [15:0] pair_val,
  input wire [11:0] offset,
  input wire [15:0] z_ptr,
  input wire [2:0] bit_sel,
  input wire [7:0] io_val,
  input wire next_two_word,
  input wire [15:0] pop_data,
  output wire ready,
  output reg done_q,
  output reg [7:0] rd_result_q,
  output reg rd_write_q,
  output reg [15:0] pair_result_q,
  output reg pair_write_q,
  output reg [7:0] status_flags_register_q,
  output reg [15:0] pc_q,
  output reg push_req_q,
  output reg [15:0] push_data_q,
  output reg pop_req_q
);

  localparam st_idle = 1'b0;
  localparam st_run = 1'b1;

  reg state_q;
  reg [2:0] rem_q;
  reg [15:0] pc_pend_q;
  reg from_stack_q;
  reg wr_rd_q;
  reg wr_pair_q;

  reg [7:0] a_s;
  reg [7:0] b_s;
  reg cin_s;
  reg [2:0] mode_s;
  reg [7:0] fmask_s;
  reg force_c_s;
  reg wr_rd_s;
  reg wr_pair_s;
  reg word_s;
  reg ones_s;
  reg [15:0] pc_t;
  reg [2:0] cyc_s;
  reg push_s;
  reg pop_s;
  reg skip_s;

  wire [7:0] alu_res;
  wire alu_c;
  wire alu_z;
  wire alu_n;
  wire alu_v;
  wire alu_h;
  wire [16:0] wsum;
  wire [16:0] wdif;
  wire [15:0] wres;
  wire wc;
  wire wv;
  wire wz;
  wire wn;
  wire [15:0] rel12;
  wire [15:0] rel7;
  wire [15:0] pc_seq;
  wire [7:0] byte_flags;
  wire [7:0] word_flags;
  wire [7:0] src_flags;
  wire [7:0] flags_new;
  wire carry_in;

  // Bit picked out of a value (status, register or I/O) by the bit select
  function sel_bit;
    input [7:0] v;
    input [2:0] s;
    begin
      sel_bit = v[s];
    end
  endfunction

  aeb_alu8 aeb_alu8_i (
    .a(a_s),
    .b(b_s),
    .cin(cin_s),
    .mode(mode_s),
    .res(alu_res),
    .c_out(alu_c),
    .z_out(alu_z),
    .n_out(alu_n),
    .v_out(alu_v),
    .h_out(alu_h)
  );

  assign carry_in = status_flags_register_q[`AEB_FLG_C];
  assign ready = (state_q == st_idle);
  assign pc_seq = pc_q + 16'h0001;
  assign rel12 = {{4{offset[11]}}, offset};
  assign rel7 = {{9{offset[6]}}, offset[6:0]};

  // Word path; constant is the low six bits of the immediate
  assign wsum = {1'b0, pair_val} + {11'h000, imm_k[5:0]};
  assign wdif = {1'b0, pair_val} - {11'h000, imm_k[5:0]};
  assign wres = (op == `AEB_OP_WORD_ADD_IMMEDIATE) ? wsum[15:0] : wdif[15:0];
  assign wc = (op == `AEB_OP_WORD_ADD_IMMEDIATE) ? wsum[16] : wdif[16];
  assign wn = wres[15];
  assign wz = (wres == 16'h0000);
  assign wv = (op == `AEB_OP_WORD_ADD_IMMEDIATE) ? (~pair_val[15] & wres[15]) :
              (pair_val[15] & ~wres[15]);

  // Candidate flag vectors; S only exists in the word vector
  assign byte_flags = {2'b00, alu_h, 1'b0, alu_v, alu_n, alu_z, alu_c | force_c_s};
  assign word_flags = {3'b000, wn ^ wv, wv, wn, wz, wc};
  assign src_flags = word_s ? word_flags : byte_flags;
  // Only masked positions change, the rest hold their old value
  assign flags_new = (status_flags_register_q & ~fmask_s) | (src_flags & fmask_s);

  // Operation decode: operands, flag mask, target, cycle count
  always @* begin
    a_s = rd_val;
    b_s = source_register;
    cin_s = 1'b0;
    mode_s = `AEB_ALU_ADD;
    fmask_s = `AEB_FM_NONE;
    force_c_s = 1'b0;
    wr_rd_s = 1'b0;
    wr_pair_s = 1'b0;
    word_s = 1'b0;
    ones_s = 1'b0;
    pc_t = pc_seq;
    cyc_s = `AEB_CYC_ONE;
    push_s = 1'b0;
    pop_s = 1'b0;
    skip_s = 1'b0;
    case (op)
      `AEB_OP_PLAIN_ADD, `AEB_OP_CARRY_ADD: begin
        cin_s = (op == `AEB_OP_CARRY_ADD) & carry_in;
        fmask_s = `AEB_FM_ARITH;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_PLAIN_SUB, `AEB_OP_MINUS_WITH_CARRY: begin
        mode_s = `AEB_ALU_SUB;
        cin_s = (op == `AEB_OP_MINUS_WITH_CARRY) & carry_in;
        fmask_s = `AEB_FM_ARITH;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_MINUS_IMMEDIATE, `AEB_OP_MINUS_CARRY_IMMEDIATE: begin
        mode_s = `AEB_ALU_SUB;
        b_s = imm_k;
        cin_s = (op == `AEB_OP_MINUS_CARRY_IMMEDIATE) & carry_in;
        fmask_s = `AEB_FM_ARITH;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_REG_AND, `AEB_OP_MASK_IMMEDIATE: begin
        mode_s = `AEB_ALU_AND;
        if (op == `AEB_OP_MASK_IMMEDIATE) b_s = imm_k;
        fmask_s = `AEB_FM_LOGIC;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_REG_OR, `AEB_OP_MERGE_IMMEDIATE: begin
        mode_s = `AEB_ALU_OR;
        if (op == `AEB_OP_MERGE_IMMEDIATE) b_s = imm_k;
        fmask_s = `AEB_FM_LOGIC;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_BITWISE_XOR: begin
        mode_s = `AEB_ALU_XOR;
        fmask_s = `AEB_FM_LOGIC;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_INVERT_ALL_BITS: begin
        // FF minus value never borrows, so carry is forced to one
        a_s = 8'hff;
        b_s = rd_val;
        mode_s = `AEB_ALU_SUB;
        force_c_s = 1'b1;
        fmask_s = `AEB_FM_INVERT;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_ZERO_MINUS_VALUE: begin
        a_s = 8'h00;
        b_s = rd_val;
        mode_s = `AEB_ALU_SUB;
        fmask_s = `AEB_FM_ARITH;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_SET_BITS_MASK, `AEB_OP_CLEAR_BITS_MASK: begin
        mode_s = (op == `AEB_OP_SET_BITS_MASK) ? `AEB_ALU_OR : `AEB_ALU_AND;
        b_s = (op == `AEB_OP_SET_BITS_MASK) ? imm_k : ~imm_k;
        fmask_s = `AEB_FM_LOGIC;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_PLUS_ONE, `AEB_OP_MINUS_ONE: begin
        // Carry is masked out so multi-byte loops keep it
        mode_s = (op == `AEB_OP_PLUS_ONE) ? `AEB_ALU_ADD : `AEB_ALU_SUB;
        b_s = 8'h01;
        fmask_s = `AEB_FM_LOGIC;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_SELF_AND_FLAGS, `AEB_OP_ZERO_REGISTER: begin
        mode_s = (op == `AEB_OP_ZERO_REGISTER) ? `AEB_ALU_XOR : `AEB_ALU_AND;
        b_s = rd_val;
        fmask_s = `AEB_FM_LOGIC;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_ALL_ONES_LOAD: begin
        ones_s = 1'b1;
        wr_rd_s = 1'b1;
      end
      `AEB_OP_WORD_ADD_IMMEDIATE, `AEB_OP_WORD_MINUS_IMMEDIATE: begin
        word_s = 1'b1;
        fmask_s = `AEB_FM_WORD;
        wr_pair_s = 1'b1;
        cyc_s = `AEB_CYC_TWO;
      end
      `AEB_OP_DIFF_FLAGS_ONLY, `AEB_OP_CARRY_DIFF_FLAGS,
      `AEB_OP_IMMEDIATE_DIFF_FLAGS: begin
        mode_s = `AEB_ALU_SUB;
        if (op == `AEB_OP_IMMEDIATE_DIFF_FLAGS) b_s = imm_k;
        cin_s = (op == `AEB_OP_CARRY_DIFF_FLAGS) & carry_in;
        fmask_s = `AEB_FM_ARITH;
      end
      `AEB_OP_RELATIVE_JUMP: begin
        pc_t = pc_q + rel12 + 16'h0001;
        cyc_s = `AEB_CYC_TWO;
      end
      `AEB_OP_POINTER_JUMP: begin
        pc_t = z_ptr;
        cyc_s = `AEB_CYC_TWO;
      end
      `AEB_OP_RELATIVE_CALL, `AEB_OP_POINTER_CALL: begin
        pc_t = (op == `AEB_OP_POINTER_CALL) ? z_ptr : pc_q + rel12 + 16'h0001;
        push_s = 1'b1;
        cyc_s = `AEB_CYC_THREE;
      end
      `AEB_OP_POP_PC_BACK, `AEB_OP_INTERRUPT_EXIT: begin
        pop_s = 1'b1;
        cyc_s = `AEB_CYC_FOUR;
      end
      `AEB_OP_SKIP_IF_EQUAL: skip_s = (rd_val == source_register);
      `AEB_OP_SKIP_REG_BIT_CLEAR: skip_s = ~sel_bit(source_register, bit_sel);
      `AEB_OP_SKIP_REG_BIT_SET: skip_s = sel_bit(source_register, bit_sel);
      `AEB_OP_SKIP_IO_BIT_CLEAR: skip_s = ~sel_bit(io_val, bit_sel);
      `AEB_OP_SKIP_IO_BIT_SET: skip_s = sel_bit(io_val, bit_sel);
      `AEB_OP_BRANCH_FLAG_SET, `AEB_OP_BRANCH_FLAG_CLEAR: begin
        if (sel_bit(status_flags_register_q, bit_sel) ==
            (op == `AEB_OP_BRANCH_FLAG_SET)) begin
          pc_t = pc_q + rel7 + 16'h0001;
          cyc_s = `AEB_CYC_TWO;
        end
      end
      default: cyc_s = `AEB_CYC_ONE;
    endcase
    // A skip steps over one or two words at one cycle per word
    if (skip_s) begin
      pc_t = next_two_word ? pc_q + 16'h0003 : pc_q + 16'h0002;
      cyc_s = next_two_word ? `AEB_CYC_THREE : `AEB_CYC_TWO;
    end
  end

  // Sequencer; flags and data latch at start, PC and write strobes at the end
  always @(posedge core_clk) begin
    if (reset) begin
      state_q <= st_idle;
      rem_q <= 3'h0;
      pc_pend_q <= `AEB_PC_RESET;
      from_stack_q <= 1'b0;
      wr_rd_q <= 1'b0;
      wr_pair_q <= 1'b0;
      done_q <= 1'b0;
      rd_result_q <= 8'h00;
      rd_write_q <= 1'b0;
      pair_result_q <= 16'h0000;
      pair_write_q <= 1'b0;
      status_flags_register_q <= `AEB_STATUS_FLAGS_REGISTER_RESET;
      pc_q <= `AEB_PC_RESET;
      push_req_q <= 1'b0;
      push_data_q <= 16'h0000;
      pop_req_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      rd_write_q <= 1'b0;
      pair_write_q <= 1'b0;
      push_req_q <= 1'b0;
      pop_req_q <= 1'b0;
      case (state_q)
        st_idle: begin
          if (start) begin
            status_flags_register_q <= flags_new;
            if (wr_rd_s) rd_result_q <= ones_s ? 8'hff : alu_res;
            if (wr_pair_s) pair_result_q <= wres;
            // Return address goes out before the PC moves
            push_req_q <= push_s;
            push_data_q <= pc_seq;
            pop_req_q <= pop_s;
            if (cyc_s == `AEB_CYC_ONE) begin
              pc_q <= pc_t;
              done_q <= 1'b1;
              rd_write_q <= wr_rd_s;
              pair_write_q <= wr_pair_s;
            end else begin
              state_q <= st_run;
              rem_q <= cyc_s - `AEB_CYC_ONE;
              pc_pend_q <= pc_t;
              from_stack_q <= pop_s;
              wr_rd_q <= wr_rd_s;
              wr_pair_q <= wr_pair_s;
            end
          end
        end
        st_run: begin
          if (rem_q == 3'h1) begin
            // Stack word is only read on the last cycle, giving it time to settle
            pc_q <= from_stack_q ? pop_data : pc_pend_q;
            done_q <= 1'b1;
            rd_write_q <= wr_rd_q;
            pair_write_q <= wr_pair_q;
            state_q <= st_idle;
          end else begin
            rem_q <= rem_q - 3'h1;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

endmodule

// *** hdl/aeb_consts.vh ***
// Constants for the byte and word execute datapath and its branch logic.
// Assumes the decoder hands over one operation code per instruction.
// How it works
// - Add, add-with-carry: sum, five flags, one cycle
// - Register subtract, with carry: five flags, one cycle
// - Immediate subtract, with carry: five flags, one cycle
// - Word add immediate: pair plus constant, two cycles
// - Word minus immediate: pair minus constant, two cycles
// - AND with register or constant: Z N V
// - OR with register or constant: Z N V
// - XOR of two registers: Z N V
// - Invert is FF minus value; negate adds H
// - Set or clear masked bits: Z N V
// - Plus/minus one keep carry, update Z N V
// - Test, clear update Z N V; all-ones no flags
// - Relative jump PC+k+1, pointer jump Z, two cycles
// - Calls three cycles; returns reload PC, four cycles
// - Equal registers skip next, PC plus 2 or 3
// - Compares subtract without writing, five flags
// - Register bit skips on clear or set bit
// - I/O bit skips on clear or set bit
// - Branch on flag set: PC+k+1, 1/2 cycles
// - Branch on flag clear: PC+k+1, flags untouched
`ifndef AEB_CONSTS_VH
`define AEB_CONSTS_VH

// Operation codes
`define AEB_OP_PLAIN_ADD 6'h00
`define AEB_OP_CARRY_ADD 6'h01
`define AEB_OP_PLAIN_SUB 6'h02
`define AEB_OP_MINUS_WITH_CARRY 6'h03
`define AEB_OP_MINUS_IMMEDIATE 6'h04
`define AEB_OP_MINUS_CARRY_IMMEDIATE 6'h05
`define AEB_OP_REG_AND 6'h06
`define AEB_OP_MASK_IMMEDIATE 6'h07
`define AEB_OP_REG_OR 6'h08
`define AEB_OP_MERGE_IMMEDIATE 6'h09
`define AEB_OP_BITWISE_XOR 6'h0a
`define AEB_OP_INVERT_ALL_BITS 6'h0b
`define AEB_OP_ZERO_MINUS_VALUE 6'h0c
`define AEB_OP_SET_BITS_MASK 6'h0d
`define AEB_OP_CLEAR_BITS_MASK 6'h0e
`define AEB_OP_PLUS_ONE 6'h0f
`define AEB_OP_MINUS_ONE 6'h10
`define AEB_OP_SELF_AND_FLAGS 6'h11
`define AEB_OP_ZERO_REGISTER 6'h12
`define AEB_OP_ALL_ONES_LOAD 6'h13
`define AEB_OP_WORD_ADD_IMMEDIATE 6'h14
`define AEB_OP_WORD_MINUS_IMMEDIATE 6'h15
`define AEB_OP_DIFF_FLAGS_ONLY 6'h16
`define AEB_OP_CARRY_DIFF_FLAGS 6'h17
`define AEB_OP_IMMEDIATE_DIFF_FLAGS 6'h18
`define AEB_OP_RELATIVE_JUMP 6'h19
`define AEB_OP_POINTER_JUMP 6'h1a
`define AEB_OP_RELATIVE_CALL 6'h1b
`define AEB_OP_POINTER_CALL 6'h1c
`define AEB_OP_POP_PC_BACK 6'h1d
`define AEB_OP_INTERRUPT_EXIT 6'h1e
`define AEB_OP_SKIP_IF_EQUAL 6'h1f
`define AEB_OP_SKIP_REG_BIT_CLEAR 6'h20
`define AEB_OP_SKIP_REG_BIT_SET 6'h21
`define AEB_OP_SKIP_IO_BIT_CLEAR 6'h22
`define AEB_OP_SKIP_IO_BIT_SET 6'h23
`define AEB_OP_BRANCH_FLAG_SET 6'h24
`define AEB_OP_BRANCH_FLAG_CLEAR 6'h25

// Status flag positions
`define AEB_FLG_C 0
`define AEB_FLG_Z 1
`define AEB_FLG_N 2
`define AEB_FLG_V 3
`define AEB_FLG_S 4
`define AEB_FLG_H 5

// Flag update masks
`define AEB_FM_NONE 8'h00
`define AEB_FM_ARITH 8'h2f
`define AEB_FM_LOGIC 8'h0e
`define AEB_FM_INVERT 8'h0f
`define AEB_FM_WORD 8'h1f
`define AEB_STATUS_FLAGS_REGISTER_RESET 8'h00
`define AEB_PC_RESET 16'h0000

// Byte ALU modes
`define AEB_ALU_ADD 3'h0
`define AEB_ALU_SUB 3'h1
`define AEB_ALU_AND 3'h2
`define AEB_ALU_OR 3'h3
`define AEB_ALU_XOR 3'h4

// Cycle counts
`define AEB_CYC_ONE 3'h1
`define AEB_CYC_TWO 3'h2
`define AEB_CYC_THREE 3'h3
`define AEB_CYC_FOUR 3'h4

`endif

// *** hdl/aeb_alu8.v ***
// Byte ALU: result and C Z N V H flags for add, subtract and logic.
// Assumes operands and mode are steady within the cycle; purely combinational.
`timescale 1ns/1ps
`include "aeb_consts.vh"

module aeb_alu8 (
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  input wire [2:0] mode,
  output reg [7:0] res,
  output reg c_out,
  output wire z_out,
  output wire n_out,
  output reg v_out,
  output reg h_out
);

  wire [8:0] sum9;
  wire [8:0] dif9;

  // Carry comes out of the ninth bit; borrow is formed from bit 7 of a, b and res
  assign sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign dif9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
  assign z_out = (res == 8'h00);
  assign n_out = res[7];

  // Logic modes clear V and leave C and H at zero
  always @* begin
    res = 8'h00;
    c_out = 1'b0;
    v_out = 1'b0;
    h_out = 1'b0;
    case (mode)
      `AEB_ALU_ADD: begin
        res = sum9[7:0];
        c_out = sum9[8];
        h_out = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
        v_out = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
      end
      `AEB_ALU_SUB: begin
        res = dif9[7:0];
        c_out = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
        h_out = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
        v_out = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
      end
      `AEB_ALU_AND: res = a & b;
      `AEB_ALU_OR: res = a | b;
      `AEB_ALU_XOR: res = a ^ b;
      default: res = 8'h00;
    endcase
  end

endmodule

// *** tb/aeb_core_properties.sv ***
// Timing and side-effect checks for the execute stage, one rule per property.
// Assumes a single core_clk domain and the synchronous, active-high reset.
`timescale 1ns/1ps
`include "aeb_consts.vh"

module aeb_core_props (
  input wire core_clk,
  input wire reset,
  input wire start,
  input wire [5:0] op,
  input wire [7:0] rd_val,
  input wire [7:0] source_register,
  input wire [11:0] offset,
  input wire [15:0] z_ptr,
  input wire [2:0] bit_sel,
  input wire next_two_word,
  input wire [15:0] pop_data,
  input wire ready,
  input wire done_q,
  input wire rd_write_q,
  input wire pair_write_q,
  input wire [7:0] status_flags_register_q,
  input wire [15:0] pc_q,
  input wire push_req_q,
  input wire [15:0] push_data_q,
  input wire pop_req_q
);
  logic [15:0] take_pc_q;
  logic [11:0] take_off_q;

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (reset);

  // Snapshot at the taking edge; targets are relative to this pc
  always @(posedge core_clk) begin
    if (start && ready) begin
      take_pc_q <= pc_q;
      take_off_q <= offset;
    end
  end

  sequence s_take(hit);
    start && ready && hit;
  endsequence
  sequence s_wait2;
    !done_q ##1 done_q;
  endsequence

  a_byte_one_cycle: assert property (s_take(op == `AEB_OP_PLAIN_ADD) |=> done_q && rd_write_q)
    else $error("byte add did not finish in one cycle");
  a_word_two_cycle: assert property (s_take(op == `AEB_OP_WORD_ADD_IMMEDIATE ||
    op == `AEB_OP_WORD_MINUS_IMMEDIATE) |=> !done_q ##1 (done_q && pair_write_q))
    else $error("word op timing wrong");
  a_rel_jump_target: assert property (s_take(op == `AEB_OP_RELATIVE_JUMP) |=> !done_q ##1
    (done_q && pc_q == take_pc_q + {{4{take_off_q[11]}}, take_off_q} + 16'h0001))
    else $error("relative jump target wrong");
  a_ptr_jump_target: assert property (s_take(op == `AEB_OP_POINTER_JUMP) |=> !done_q ##1
    (done_q && pc_q == $past(z_ptr, 2)))
    else $error("pointer jump timing wrong");
  a_call_push_first: assert property (s_take(op == `AEB_OP_RELATIVE_CALL ||
    op == `AEB_OP_POINTER_CALL) |=> (push_req_q && push_data_q == take_pc_q + 16'h0001)
    ##1 s_wait2)
    else $error("call push or timing wrong");
  a_return_reload: assert property (s_take(op == `AEB_OP_POP_PC_BACK ||
    op == `AEB_OP_INTERRUPT_EXIT) |=> pop_req_q ##1 !done_q ##1 !done_q ##1
    (done_q && pc_q == $past(pop_data)))
    else $error("return reload wrong");
  a_skip_two_word: assert property (s_take(op == `AEB_OP_SKIP_IF_EQUAL && next_two_word &&
    rd_val == source_register) |=> !done_q[*2] ##1 (done_q && pc_q == take_pc_q + 16'h0003))
    else $error("two-word skip wrong");
  a_flags_untouched: assert property (s_take(op == `AEB_OP_ALL_ONES_LOAD ||
    op == `AEB_OP_BRANCH_FLAG_SET || op == `AEB_OP_BRANCH_FLAG_CLEAR ||
    op == `AEB_OP_RELATIVE_JUMP) |=> $stable(status_flags_register_q))
    else $error("flags changed unexpectedly");
  a_carry_kept: assert property (s_take(op == `AEB_OP_PLUS_ONE || op == `AEB_OP_MINUS_ONE)
    |=> $stable(status_flags_register_q[`AEB_FLG_C]))
    else $error("plus or minus one changed carry");
  a_branch_taken: assert property (s_take(op == `AEB_OP_BRANCH_FLAG_SET &&
    status_flags_register_q[bit_sel]) |=> s_wait2)
    else $error("taken branch timing wrong");
  a_branch_fall: assert property (s_take(op == `AEB_OP_BRANCH_FLAG_CLEAR &&
    status_flags_register_q[bit_sel]) |=> done_q)
    else $error("untaken branch timing wrong");
  a_compare_no_write: assert property (s_take(op == `AEB_OP_DIFF_FLAGS_ONLY ||
    op == `AEB_OP_CARRY_DIFF_FLAGS || op == `AEB_OP_IMMEDIATE_DIFF_FLAGS)
    |=> done_q && !rd_write_q)
    else $error("compare wrote a register");
endmodule

bind aeb_core aeb_core_props aeb_core_props_i (.core_clk, .reset, .start, .op, .rd_val,
  .source_register, .offset, .z_ptr, .bit_sel, .next_two_word, .pop_data, .ready, .done_q,
  .rd_write_q, .pair_write_q, .status_flags_register_q, .pc_q, .push_req_q, .push_data_q,
  .pop_req_q);

// *** tb/tb_alu_and_branch_execute.sv ***
// Self-checking bench for the execute stage: byte ops from a table, then flow.
// Assumes the stack lives here: pop_data is driven by the bench.
`timescale 1ns/1ps
`include "aeb_consts.vh"

module tb_alu_and_branch_execute;
  typedef struct {logic [5:0] op; logic [7:0] a, b, k, res, fl; logic wr;} aeb_row_t;
  logic core_clk = 1'b0, reset = 1'b1, start = 1'b0, next_two_word = 1'b0;
  logic [5:0] op = 6'h00;
  logic [7:0] rd_val = 8'h00, source_register = 8'h00, imm_k = 8'h00, io_val = 8'h00;
  logic [15:0] pair_val = 16'h0000, z_ptr = 16'h0000, pop_data = 16'h0000, exp_pc, push_val;
  logic [11:0] offset = 12'h000;
  logic [2:0] bit_sel = 3'h0;
  logic push_seen, pop_seen, wr_seen, pw_seen;
  wire ready, done_q, rd_write_q, pair_write_q, push_req_q, pop_req_q;
  wire [7:0] rd_result_q, status_flags_register_q;
  wire [15:0] pair_result_q, pc_q, push_data_q;
  int error_cnt = 0, compares = 0;
  // Flags chain row to row: each carry row's carry-in is the previous row's C
  aeb_row_t rows [24] = '{
    '{`AEB_OP_PLAIN_ADD, 8'h0f, 8'h01, 8'h00, 8'h10, 8'h20, 1'b1},
    '{`AEB_OP_PLAIN_ADD, 8'hff, 8'h01, 8'h00, 8'h00, 8'h23, 1'b1},
    '{`AEB_OP_CARRY_ADD, 8'h01, 8'h01, 8'h00, 8'h03, 8'h00, 1'b1},
    '{`AEB_OP_PLAIN_SUB, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h20, 1'b1},
    '{`AEB_OP_MINUS_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'hff, 8'h25, 1'b1},
    '{`AEB_OP_MINUS_WITH_CARRY, 8'h05, 8'h02, 8'h00, 8'h02, 8'h00, 1'b1},
    '{`AEB_OP_MINUS_CARRY_IMMEDIATE, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h28, 1'b1},
    '{`AEB_OP_REG_AND, 8'hf0, 8'h3c, 8'h00, 8'h30, 8'h20, 1'b1},
    '{`AEB_OP_MASK_IMMEDIATE, 8'h0f, 8'h00, 8'hf0, 8'h00, 8'h22, 1'b1},
    '{`AEB_OP_REG_OR, 8'h80, 8'h01, 8'h00, 8'h81, 8'h24, 1'b1},
    '{`AEB_OP_MERGE_IMMEDIATE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h22, 1'b1},
    '{`AEB_OP_BITWISE_XOR, 8'haa, 8'hff, 8'h00, 8'h55, 8'h20, 1'b1},
    '{`AEB_OP_INVERT_ALL_BITS, 8'h0f, 8'h00, 8'h00, 8'hf0, 8'h25, 1'b1},
    '{`AEB_OP_ZERO_MINUS_VALUE, 8'h01, 8'h00, 8'h00, 8'hff, 8'h25, 1'b1},
    '{`AEB_OP_SET_BITS_MASK, 8'h01, 8'h00, 8'h80, 8'h81, 8'h25, 1'b1},
    '{`AEB_OP_CLEAR_BITS_MASK, 8'h81, 8'h00, 8'h81, 8'h00, 8'h23, 1'b1},
    '{`AEB_OP_PLUS_ONE, 8'h7f, 8'h00, 8'h00, 8'h80, 8'h2d, 1'b1},
    '{`AEB_OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h7f, 8'h29, 1'b1},
    '{`AEB_OP_SELF_AND_FLAGS, 8'h00, 8'h00, 8'h00, 8'h00, 8'h23, 1'b1},
    '{`AEB_OP_ZERO_REGISTER, 8'h5a, 8'h5a, 8'h00, 8'h00, 8'h23, 1'b1},
    '{`AEB_OP_ALL_ONES_LOAD, 8'h12, 8'h00, 8'h00, 8'hff, 8'h23, 1'b1},
    '{`AEB_OP_DIFF_FLAGS_ONLY, 8'h01, 8'h02, 8'h00, 8'h00, 8'h25, 1'b0},
    '{`AEB_OP_CARRY_DIFF_FLAGS, 8'h02, 8'h01, 8'h00, 8'h00, 8'h02, 1'b0},
    '{`AEB_OP_IMMEDIATE_DIFF_FLAGS, 8'h80, 8'h00, 8'h01, 8'h00, 8'h28, 1'b0}};

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end

  aeb_core aeb_core_i (.core_clk, .reset, .start, .op, .rd_val, .source_register, .imm_k,
    .pair_val, .offset, .z_ptr, .bit_sel, .io_val, .next_two_word, .pop_data, .ready,
    .done_q, .rd_result_q, .rd_write_q, .pair_result_q, .pair_write_q,
    .status_flags_register_q, .pc_q, .push_req_q, .push_data_q, .pop_req_q);

  always #50 core_clk = ~core_clk;

  // Issue one instruction at a falling edge, count cycles up to done
  // Start stays up after a one-cycle op, so the next call issues back to back
  task automatic run(input logic [5:0] o, input int n, input logic [15:0] epc);
    int cnt;
    op = o;
    start = 1'b1;
    @(negedge core_clk);
    cnt = 1;
    push_seen = push_req_q;
    push_val = push_data_q;
    pop_seen = pop_req_q;
    while (done_q !== 1'b1 && cnt < 8) begin
      start = 1'b0;
      @(negedge core_clk);
      cnt++;
    end
    wr_seen = rd_write_q;
    pw_seen = pair_write_q;
    `CHK("cycles", n, cnt)
    `CHK("pc", epc, pc_q)
    exp_pc = epc;
  endtask

  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog: the sequence needs under a hundred cycles
  initial begin
    #(3000 * 100);
    error_cnt++;
    close_out;
  end

  initial begin
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    `CHK("pc_rst", 16'h0000, pc_q)
    exp_pc = 16'h0000;
    foreach (rows[i]) begin
      rd_val = rows[i].a;
      source_register = rows[i].b;
      imm_k = rows[i].k;
      run(rows[i].op, 1, exp_pc + 16'h0001);
      `CHK("flags", rows[i].fl, status_flags_register_q)
      `CHK("write", rows[i].wr, wr_seen)
      if (rows[i].wr) `CHK("result", rows[i].res, rd_result_q)
    end
    // Word ops across the byte boundary and through zero
    pair_val = 16'h00ff;
    imm_k = 8'h01;
    run(`AEB_OP_WORD_ADD_IMMEDIATE, 2, exp_pc + 16'h0001);
    `CHK("wsum", {16'h0100, 8'h20, 1'b1}, {pair_result_q, status_flags_register_q, pw_seen})
    pair_val = 16'h0000;
    run(`AEB_OP_WORD_MINUS_IMMEDIATE, 2, exp_pc + 16'h0001);
    `CHK("wdif", {16'hffff, 8'h35}, {pair_result_q, status_flags_register_q})
    // Jumps, calls and returns; most negative relative offset
    offset = 12'h800;
    run(`AEB_OP_RELATIVE_JUMP, 2, exp_pc + 16'hf801);
    z_ptr = 16'h1234;
    run(`AEB_OP_POINTER_JUMP, 2, 16'h1234);
    offset = 12'h005;
    run(`AEB_OP_RELATIVE_CALL, 3, exp_pc + 16'h0006);
    `CHK("push", {1'b1, 16'h1235}, {push_seen, push_val})
    z_ptr = 16'h0300;
    run(`AEB_OP_POINTER_CALL, 3, 16'h0300);
    `CHK("push", {1'b1, 16'h123b}, {push_seen, push_val})
    pop_data = 16'h0abc;
    run(`AEB_OP_POP_PC_BACK, 4, 16'h0abc);
    `CHK("pop", 1'b1, pop_seen)
    pop_data = 16'h0def;
    run(`AEB_OP_INTERRUPT_EXIT, 4, 16'h0def);
    // Skips: equal one-word, equal two-word, unequal
    rd_val = 8'h33;
    source_register = 8'h33;
    run(`AEB_OP_SKIP_IF_EQUAL, 2, exp_pc + 16'h0002);
    next_two_word = 1'b1;
    run(`AEB_OP_SKIP_IF_EQUAL, 3, exp_pc + 16'h0003);
    source_register = 8'h34;
    run(`AEB_OP_SKIP_IF_EQUAL, 1, exp_pc + 16'h0001);
    next_two_word = 1'b0;
    source_register = 8'h10;
    // I/O value is the inverse, so a variant reading the wrong operand trips
    io_val = 8'hef;
    for (int j = 0; j < 8; j++) begin
      bit_sel = (j < 4) ? 3'h4 : 3'h3;
      if (((j % 2 == 1) == (j < 4)) != (j % 4 >= 2))
        run(`AEB_OP_SKIP_REG_BIT_CLEAR + 6'(j % 4), 2, exp_pc + 16'h0002);
      else
        run(`AEB_OP_SKIP_REG_BIT_CLEAR + 6'(j % 4), 1, exp_pc + 16'h0001);
    end
    // Branches with flags 0x35: C set, Z clear
    offset = 12'h07f;
    bit_sel = 3'h0;
    run(`AEB_OP_BRANCH_FLAG_SET, 2, exp_pc);
    run(`AEB_OP_BRANCH_FLAG_CLEAR, 1, exp_pc + 16'h0001);
    bit_sel = 3'h1;
    run(`AEB_OP_BRANCH_FLAG_SET, 1, exp_pc + 16'h0001);
    offset = 12'h03f;
    run(`AEB_OP_BRANCH_FLAG_CLEAR, 2, exp_pc + 16'h0040);
    `CHK("brflags", 8'h35, status_flags_register_q)
    // Start held into the busy cycle with another op: only one runs
    op = `AEB_OP_WORD_ADD_IMMEDIATE;
    start = 1'b1;
    @(negedge core_clk);
    op = `AEB_OP_PLAIN_ADD;
    @(negedge core_clk);
    start = 1'b0;
    @(negedge core_clk);
    `CHK("busy", {1'b0, exp_pc + 16'h0001}, {done_q, pc_q})
    // Reset in mid-instruction
    run(`AEB_OP_POINTER_JUMP, 2, 16'h0300);
    op = `AEB_OP_RELATIVE_CALL;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    `CHK("rst", {1'b1, 16'h0000, 8'h00}, {ready, pc_q, status_flags_register_q})
    // The aborted call must not finish or push after the release edge
    @(negedge core_clk);
    `CHK("rst2", {1'b1, 1'b0, 1'b0, 16'h0000}, {ready, done_q, push_req_q, pc_q})
    close_out;
  end
endmodule
